/* File: rtl/pmio_match_cmp.sv */
// Registered port mismatch detector for ports 0 and 1.
`timescale 1ns/100ps
module pmio_match_cmp
	import pmio_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire pmio_byte_t pins0,
	input  wire pmio_byte_t mask0,
	input  wire pmio_byte_t expect0,
	input  wire pmio_byte_t pins1,
	input  wire pmio_byte_t mask1,
	input  wire pmio_byte_t expect1,
	output logic            mismatch
);

	logic mismatch_reg;
	logic mismatch_next;

	// Masked compare of both ports; a zero mask bit can never contribute.
	assign mismatch_next = masked_differs(pins0, mask0, expect0)
		| masked_differs(pins1, mask1, expect1);

	// The flag is registered before it leaves the block.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mismatch_reg <= 1'b0;
		end else begin
			mismatch_reg <= mismatch_next;
		end
	end

	assign mismatch = mismatch_reg;

endmodule : pmio_match_cmp

/* File: rtl/pmio_pin_sync.sv */
// Three-stage pin synchronizer that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module pmio_pin_sync
	import pmio_pkg::*;
#(
	parameter int               WIDTH     = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pin_async,
	output logic      [WIDTH-1:0] pin_stable
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] stable_reg;
	logic [WIDTH-1:0] stable_next;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_reg <= RESET_VAL;
			s2_reg <= RESET_VAL;
			s3_reg <= RESET_VAL;
		end else begin
			s1_reg <= pin_async;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// A bit follows stages two and three only when they agree.
	assign stable_next = (s2_reg & s3_reg) | (stable_reg & (s2_reg | s3_reg));

	// Filtered level.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stable_reg <= RESET_VAL;
		end else begin
			stable_reg <= stable_next;
		end
	end

	assign pin_stable = stable_reg;

endmodule : pmio_pin_sync

/* File: rtl/pmio_pkg.sv */
// Constants, register map and helper functions of the port match and I/O block.
package pmio_pkg;

	typedef logic [7:0] pmio_byte_t;

	localparam int NPORTS = 3;

	// Register byte addresses, one per port where a port has the register.
	localparam pmio_byte_t ADDR_DATA  [NPORTS] = '{8'h80, 8'h90, 8'ha0};
	localparam pmio_byte_t ADDR_SKIP  [NPORTS] = '{8'hd4, 8'hd5, 8'hd6};
	localparam pmio_byte_t ADDR_MDIN  [NPORTS] = '{8'hf1, 8'hf2, 8'hf3};
	localparam pmio_byte_t ADDR_MDOUT [NPORTS] = '{8'ha4, 8'ha5, 8'ha6};
	localparam pmio_byte_t ADDR_DRV   [NPORTS] = '{8'hc9, 8'hca, 8'hcb};
	localparam pmio_byte_t ADDR_MASK  [2]      = '{8'hc7, 8'hbf};
	localparam pmio_byte_t ADDR_MAT   [2]      = '{8'hd7, 8'hcf};

	// Implemented pins of each port; port 2 has only pin 7.
	localparam pmio_byte_t PORT_BITS  [NPORTS] = '{8'hff, 8'hff, 8'h80};
	// Pins that may be put in analog mode; port 2 pin 7 is digital only.
	localparam pmio_byte_t ANALOG_OK  [NPORTS] = '{8'hff, 8'hff, 8'h00};

	// Values after reset.
	localparam pmio_byte_t RST_LATCH = 8'hff;
	localparam pmio_byte_t RST_SKIP  = 8'h00;
	localparam pmio_byte_t RST_MDIN  = 8'hff;
	localparam pmio_byte_t RST_MDOUT = 8'h00;
	localparam pmio_byte_t RST_DRV   = 8'h00;
	localparam pmio_byte_t RST_MASK  = 8'h00;
	localparam pmio_byte_t RST_MAT   = 8'hff;
	localparam pmio_byte_t RST_PIN   = 8'hff;
	localparam pmio_byte_t RST_RDATA = 8'h00;

	// Width of the bit index inside a bit address.
	localparam int BIT_IDX_W = 3;

	// Maps a bit address onto the byte address of its register.
	function automatic pmio_byte_t bit_home(input pmio_byte_t addr);
		bit_home = {addr[7:BIT_IDX_W], 3'h0};
	endfunction : bit_home

	// Replaces one bit of a byte and keeps the others.
	function automatic pmio_byte_t set_bit(input pmio_byte_t old, input logic [2:0] idx,
		input logic val);
		pmio_byte_t tmp;
		tmp = old;
		tmp[idx] = val;
		set_bit = tmp;
	endfunction : set_bit

	// True when the masked pins differ from the masked expected value.
	function automatic logic masked_differs(input pmio_byte_t pins, input pmio_byte_t mask,
		input pmio_byte_t expect_val);
		masked_differs = (pins & mask) != (expect_val & mask);
	endfunction : masked_differs

endpackage : pmio_pkg

/* File: rtl/pmio_port_io.sv */
// Port data, configuration and match registers with pin control for ports 0, 1 and pin 2.7.
//
// Operation
// - Port 0 masked pins compared to expected bits.
// - Port 1 expected bits used where mask set.
// - Masked inequality on either port raises mismatch.
// - Unmasked pins never cause a mismatch.
// - Data registers writable by byte and bit.
// - Writes held in output latch until next.
// - Ordinary reads return present pin levels.
// - Read-modify-write reads the latch, not pins.
// - Skip bit set means crossbar skips pin.
// - Input mode per pin, never changed automatically.
// - Pin 2.7 stays digital, no analog mode.
// - Output mode bit picks open-drain or push-pull.
// - SMBus pins forced open-drain regardless.
// - Drive strength per pin, low after reset.
`timescale 1ns/100ps
module pmio_port_io
	import pmio_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire pmio_byte_t sfr_addr,
	input  wire logic       sfr_bit,
	input  wire logic       sfr_wr,
	input  wire pmio_byte_t sfr_wdata,
	input  wire logic       sfr_rd,
	input  wire logic       sfr_rmw,
	output pmio_byte_t      sfr_rdata,
	input  wire pmio_byte_t p0_pin_in,
	output pmio_byte_t      p0_pin_out,
	output pmio_byte_t      p0_pin_oe,
	input  wire pmio_byte_t p1_pin_in,
	output pmio_byte_t      p1_pin_out,
	output pmio_byte_t      p1_pin_oe,
	input  wire logic       p2_7_pin_in,
	output logic            p2_7_pin_out,
	output logic            p2_7_pin_oe,
	input  wire pmio_byte_t p0_smbus_pins,
	input  wire pmio_byte_t p1_smbus_pins,
	output pmio_byte_t      p0_crossbar_skip_bits,
	output pmio_byte_t      p1_crossbar_skip_bits,
	output logic            p2_7_crossbar_skip_bit,
	output pmio_byte_t      p0_drive_strength_bits,
	output pmio_byte_t      p1_drive_strength_bits,
	output logic            p2_7_drive_strength_bit,
	output pmio_byte_t      p0_input_mode_bits,
	output pmio_byte_t      p1_input_mode_bits,
	output logic            port_mismatch
);

	pmio_byte_t latch_reg     [NPORTS];
	pmio_byte_t skip_reg      [NPORTS];
	pmio_byte_t mdin_reg      [NPORTS];
	pmio_byte_t mdout_reg     [NPORTS];
	pmio_byte_t drv_reg       [NPORTS];
	pmio_byte_t mask_reg      [2];
	pmio_byte_t mat_reg       [2];
	pmio_byte_t out_reg       [NPORTS];
	pmio_byte_t oe_reg        [NPORTS];
	pmio_byte_t pin_stable    [NPORTS];
	pmio_byte_t pin_dig       [NPORTS];
	pmio_byte_t od_force      [NPORTS];
	pmio_byte_t eff_addr;
	logic [2:0] bit_idx;
	logic       sel_data      [NPORTS];
	logic       sel_skip      [NPORTS];
	logic       sel_mdin      [NPORTS];
	logic       sel_mdout     [NPORTS];
	logic       sel_drv       [NPORTS];
	logic       sel_mask      [2];
	logic       sel_mat       [2];
	pmio_byte_t rdata_reg;
	pmio_byte_t rdata_next;
	logic       p2_stable;

	// Pin synchronizers for the asynchronous pad inputs.
	pmio_pin_sync #(.WIDTH(8), .RESET_VAL(RST_PIN)) u_sync_p0 (
		.clk        (clk),
		.reset      (reset),
		.pin_async  (p0_pin_in),
		.pin_stable (pin_stable[0])
	);
	pmio_pin_sync #(.WIDTH(8), .RESET_VAL(RST_PIN)) u_sync_p1 (
		.clk        (clk),
		.reset      (reset),
		.pin_async  (p1_pin_in),
		.pin_stable (pin_stable[1])
	);
	pmio_pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_p2 (
		.clk        (clk),
		.reset      (reset),
		.pin_async  (p2_7_pin_in),
		.pin_stable (p2_stable)
	);
	assign pin_stable[2] = {p2_stable, 7'h00};

	// Bit accesses address the byte holding the bit.
	assign eff_addr = sfr_bit ? bit_home(sfr_addr) : sfr_addr;
	assign bit_idx  = sfr_addr[2:0];

	// Address decode, digital pin view and forced open-drain pins.
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			sel_data[p]  = eff_addr == ADDR_DATA[p];
			sel_skip[p]  = !sfr_bit && (sfr_addr == ADDR_SKIP[p]);
			sel_mdin[p]  = !sfr_bit && (sfr_addr == ADDR_MDIN[p]);
			sel_mdout[p] = !sfr_bit && (sfr_addr == ADDR_MDOUT[p]);
			sel_drv[p]   = !sfr_bit && (sfr_addr == ADDR_DRV[p]);
			pin_dig[p]   = pin_stable[p] & mdin_reg[p] & PORT_BITS[p];
		end
		for (int p = 0; p < 2; p++) begin
			sel_mask[p] = !sfr_bit && (sfr_addr == ADDR_MASK[p]);
			sel_mat[p]  = !sfr_bit && (sfr_addr == ADDR_MAT[p]);
		end
		od_force[0] = p0_smbus_pins;
		od_force[1] = p1_smbus_pins;
		od_force[2] = 8'h00;
	end

	// Output latches; a bit write merges into the latch, never the pins.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int p = 0; p < NPORTS; p++) begin
				latch_reg[p] <= RST_LATCH & PORT_BITS[p];
			end
		end else begin
			for (int p = 0; p < NPORTS; p++) begin
				if (sfr_wr && sel_data[p]) begin
					if (sfr_bit) begin
						latch_reg[p] <= set_bit(latch_reg[p], bit_idx, sfr_wdata[0])
							& PORT_BITS[p];
					end else begin
						latch_reg[p] <= sfr_wdata & PORT_BITS[p];
					end
				end
			end
		end
	end

	// Pin configuration registers; only software changes them.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int p = 0; p < NPORTS; p++) begin
				skip_reg[p]  <= RST_SKIP & PORT_BITS[p];
				mdin_reg[p]  <= RST_MDIN & PORT_BITS[p];
				mdout_reg[p] <= RST_MDOUT & PORT_BITS[p];
				drv_reg[p]   <= RST_DRV & PORT_BITS[p];
			end
		end else begin
			for (int p = 0; p < NPORTS; p++) begin
				if (sfr_wr && sel_skip[p]) begin
					skip_reg[p] <= sfr_wdata & PORT_BITS[p];
				end
				if (sfr_wr && sel_mdin[p]) begin
					mdin_reg[p] <= (sfr_wdata | ~ANALOG_OK[p]) & PORT_BITS[p];
				end
				if (sfr_wr && sel_mdout[p]) begin
					mdout_reg[p] <= sfr_wdata & PORT_BITS[p];
				end
				if (sfr_wr && sel_drv[p]) begin
					drv_reg[p] <= sfr_wdata & PORT_BITS[p];
				end
			end
		end
	end

	// Match mask and expected value registers.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int p = 0; p < 2; p++) begin
				mask_reg[p] <= RST_MASK;
				mat_reg[p]  <= RST_MAT;
			end
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (sfr_wr && sel_mask[p]) begin
					mask_reg[p] <= sfr_wdata;
				end
				if (sfr_wr && sel_mat[p]) begin
					mat_reg[p] <= sfr_wdata;
				end
			end
		end
	end

	// Pad drivers: open-drain drives only lows, SMBus pins never drive high.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int p = 0; p < NPORTS; p++) begin
				out_reg[p] <= RST_LATCH & PORT_BITS[p];
				oe_reg[p]  <= ~RST_LATCH & PORT_BITS[p];
			end
		end else begin
			for (int p = 0; p < NPORTS; p++) begin
				out_reg[p] <= latch_reg[p];
				oe_reg[p]  <= (~latch_reg[p] | (mdout_reg[p] & ~od_force[p]))
					& PORT_BITS[p];
			end
		end
	end

	// Read data: pins for a plain read, the latch for read-modify-write.
	always_comb begin
		rdata_next = 8'h00;
		for (int p = 0; p < NPORTS; p++) begin
			if (sel_data[p]) begin
				rdata_next = sfr_rmw ? latch_reg[p] : pin_dig[p];
			end
			if (sel_skip[p]) begin
				rdata_next = skip_reg[p];
			end
			if (sel_mdin[p]) begin
				rdata_next = mdin_reg[p];
			end
			if (sel_mdout[p]) begin
				rdata_next = mdout_reg[p];
			end
			if (sel_drv[p]) begin
				rdata_next = drv_reg[p];
			end
		end
		for (int p = 0; p < 2; p++) begin
			if (sel_mask[p]) begin
				rdata_next = mask_reg[p];
			end
			if (sel_mat[p]) begin
				rdata_next = mat_reg[p];
			end
		end
		if (sfr_bit) begin
			rdata_next = {7'h00, rdata_next[bit_idx]};
		end
	end

	// Read data register, loaded on a read strobe and held otherwise.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= RST_RDATA;
		end else if (sfr_rd) begin
			rdata_reg <= rdata_next;
		end
	end

	// Mismatch detector on synchronized, digital pin levels.
	pmio_match_cmp u_match (
		.clk      (clk),
		.reset    (reset),
		.pins0    (pin_dig[0]),
		.mask0    (mask_reg[0]),
		.expect0  (mat_reg[0]),
		.pins1    (pin_dig[1]),
		.mask1    (mask_reg[1]),
		.expect1  (mat_reg[1]),
		.mismatch (port_mismatch)
	);

	// Output wiring.
	assign sfr_rdata               = rdata_reg;
	assign p0_pin_out              = out_reg[0];
	assign p0_pin_oe               = oe_reg[0];
	assign p1_pin_out              = out_reg[1];
	assign p1_pin_oe               = oe_reg[1];
	assign p2_7_pin_out            = out_reg[2][7];
	assign p2_7_pin_oe             = oe_reg[2][7];
	assign p0_crossbar_skip_bits   = skip_reg[0];
	assign p1_crossbar_skip_bits   = skip_reg[1];
	assign p2_7_crossbar_skip_bit  = skip_reg[2][7];
	assign p0_drive_strength_bits  = drv_reg[0];
	assign p1_drive_strength_bits  = drv_reg[1];
	assign p2_7_drive_strength_bit = drv_reg[2][7];
	assign p0_input_mode_bits      = mdin_reg[0];
	assign p1_input_mode_bits      = mdin_reg[1];

	// Checks of the register, pin and match behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_mismatch_value;
		1'b1 |=> port_mismatch == $past(((pin_dig[0] ^ mat_reg[0]) & mask_reg[0]) != 8'h00
			|| ((pin_dig[1] ^ mat_reg[1]) & mask_reg[1]) != 8'h00);
	endproperty
	a_mismatch_value: assert property (p_mismatch_value)
		else $error("mismatch flag does not follow masked compare");

	property p_mask_zero;
		(mask_reg[0] == 8'h00 && mask_reg[1] == 8'h00) |=> !port_mismatch;
	endproperty
	a_mask_zero: assert property (p_mask_zero)
		else $error("mismatch raised with all mask bits clear");

	property p_p0_bit_differs;
		(mask_reg[0] & (pin_dig[0] ^ mat_reg[0])) != 8'h00
			|=> port_mismatch;
	endproperty
	a_p0_bit_differs: assert property (p_p0_bit_differs)
		else $error("masked port 0 pin unlike its expected bit not flagged");

	property p_latch_hold;
		!(sfr_wr && sel_data[0]) |=> $stable(latch_reg[0]);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("port 0 latch changed without a write");

	property p_byte_write;
		(sfr_wr && !sfr_bit && sfr_addr == ADDR_DATA[0]) |=> latch_reg[0] == $past(sfr_wdata);
	endproperty
	a_byte_write: assert property (p_byte_write)
		else $error("byte write not stored in port 0 latch");

	property p_bit_write;
		(sfr_wr && sfr_bit && bit_home(sfr_addr) == ADDR_DATA[0]) |=>
			latch_reg[0] == set_bit($past(latch_reg[0]), $past(bit_idx), $past(sfr_wdata[0]));
	endproperty
	a_bit_write: assert property (p_bit_write)
		else $error("bit write disturbed other port 0 latch bits");

	property p_read_pin;
		(sfr_rd && !sfr_rmw && !sfr_bit && sfr_addr == ADDR_DATA[0]) |=>
			sfr_rdata == $past(pin_dig[0]);
	endproperty
	a_read_pin: assert property (p_read_pin)
		else $error("plain read did not return pin levels");

	property p_read_latch;
		(sfr_rd && sfr_rmw && !sfr_bit && sfr_addr == ADDR_DATA[0]) |=>
			sfr_rdata == $past(latch_reg[0]);
	endproperty
	a_read_latch: assert property (p_read_latch)
		else $error("read-modify-write read did not return the latch");

	property p_smbus_od;
		1'b1 |=> (p0_pin_oe & p0_pin_out & $past(p0_smbus_pins)) == 8'h00;
	endproperty
	a_smbus_od: assert property (p_smbus_od)
		else $error("SMBus pin driven high");

	property p_p27_digital;
		(sfr_rd && !sfr_bit && sfr_addr == ADDR_MDIN[2]) |=> sfr_rdata[7];
	endproperty
	a_p27_digital: assert property (p_p27_digital)
		else $error("pin 2.7 reads as analog mode");

	c_mismatch_rise: cover property ($rose(port_mismatch));
	c_rmw_read: cover property (sfr_rd && sfr_rmw ##1 sfr_wr);
	c_bit_write: cover property (sfr_wr && sfr_bit && sel_data[0]);

endmodule : pmio_port_io

/* File: testbench/pmio_pin_partner.sv */
// Model of the board circuitry on one port: pull-ups and open-drain pull-downs.
`timescale 1ns/100ps
module pmio_pin_partner #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] pin_out,
	input  wire logic [WIDTH-1:0] pin_oe,
	input  wire logic [WIDTH-1:0] pull_low,
	output logic      [WIDTH-1:0] pin_level
);
	// A released pin floats to the pull-up level; any low driver wins.
	assign pin_level = ~((pin_oe & ~pin_out) | pull_low);
endmodule : pmio_pin_partner

/* File: testbench/pmio_port_io_tb.sv */
// Self-checking testbench of the port match and I/O block.
`timescale 1ns/100ps
module pmio_port_io_tb import pmio_pkg::*;;
	logic       clk, reset, sfr_bit, sfr_wr, sfr_rd, sfr_rmw;
	pmio_byte_t sfr_addr, sfr_wdata, sfr_rdata, p0_sm, p1_sm;
	pmio_byte_t p0_in, p0_out, p0_oe, p1_in, p1_out, p1_oe, p0_low, p1_low;
	logic       p2_in, p2_out, p2_oe, p2_low, p2_skip, p2_drv, port_mismatch;
	pmio_byte_t p0_skip, p1_skip, p0_drv, p1_drv, p0_mdin, p1_mdin;
	int         err_count, checked;

	pmio_port_io u_pmio_port_io (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
		.sfr_bit(sfr_bit), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
		.sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .p0_pin_in(p0_in), .p0_pin_out(p0_out),
		.p0_pin_oe(p0_oe), .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe),
		.p2_7_pin_in(p2_in), .p2_7_pin_out(p2_out), .p2_7_pin_oe(p2_oe),
		.p0_smbus_pins(p0_sm), .p1_smbus_pins(p1_sm), .p0_crossbar_skip_bits(p0_skip),
		.p1_crossbar_skip_bits(p1_skip), .p2_7_crossbar_skip_bit(p2_skip),
		.p0_drive_strength_bits(p0_drv), .p1_drive_strength_bits(p1_drv),
		.p2_7_drive_strength_bit(p2_drv), .p0_input_mode_bits(p0_mdin),
		.p1_input_mode_bits(p1_mdin), .port_mismatch(port_mismatch));
	pmio_pin_partner #(.WIDTH(8)) u_pmio_pin_partner0 (.pin_out(p0_out), .pin_oe(p0_oe),
		.pull_low(p0_low), .pin_level(p0_in));
	pmio_pin_partner #(.WIDTH(8)) u_pmio_pin_partner1 (.pin_out(p1_out), .pin_oe(p1_oe),
		.pull_low(p1_low), .pin_level(p1_in));
	pmio_pin_partner #(.WIDTH(1)) u_pmio_pin_partner2 (.pin_out(p2_out), .pin_oe(p2_oe),
		.pull_low(p2_low), .pin_level(p2_in));

	// Clock of 100 ns period.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// Compares one value against its expectation.
	task automatic check(input pmio_byte_t seen, input pmio_byte_t exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Waits whole cycles, ending just after an edge.
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask : settle

	// One write strobe of a byte or a bit.
	task automatic wr(input pmio_byte_t a, input pmio_byte_t d, input logic b = 1'b0);
		settle(1);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_bit = b;
		sfr_wr = 1'b1;
		settle(1);
		sfr_wr = 1'b0;
		sfr_bit = 1'b0;
	endtask : wr

	// One read strobe whose registered answer is compared with exp.
	task automatic rchk(input pmio_byte_t a, input pmio_byte_t exp, input logic b = 1'b0,
		input logic m = 1'b0);
		settle(1);
		sfr_addr = a;
		sfr_bit = b;
		sfr_rmw = m;
		sfr_rd = 1'b1;
		settle(1);
		sfr_rd = 1'b0;
		sfr_rmw = 1'b0;
		sfr_bit = 1'b0;
		check(sfr_rdata, exp);
	endtask : rchk

	// Waits a bounded time for the mismatch level, then compares it.
	task automatic wait_mis(input logic e);
		repeat (12) begin
			if (port_mismatch === e) break;
			settle(1);
		end
		check({7'h0, port_mismatch}, {7'h0, e});
	endtask : wait_mis

	// Outputs and registers after reset.
	task automatic t_reset();
		check(p0_out, 8'hff);
		check(p0_oe, 8'h00);
		check(p1_out, 8'hff);
		check(p1_oe, 8'h00);
		check({p2_out, p2_oe, 6'h0}, 8'h80);
		check(p0_skip, 8'h00);
		check({p2_drv, p0_drv[6:0]}, 8'h00);
		check(p1_drv, 8'h00);
		check(p1_mdin, 8'hff);
		check({7'h0, port_mismatch}, 8'h00);
		rchk(ADDR_MASK[1], 8'h00);
		rchk(ADDR_MAT[0], 8'hff);
		rchk(ADDR_MAT[1], 8'hff);
	endtask : t_reset

	// Latch writes, pin reads, read-modify-write reads and bit access.
	task automatic t_latch();
		wr(ADDR_DATA[0], 8'h5a);
		settle(1);
		check(p0_out, 8'h5a);
		check(p0_oe, 8'ha5);
		p0_low = 8'h82;
		settle(6);
		rchk(ADDR_DATA[0], 8'h58);
		rchk(ADDR_DATA[0], 8'h5a, 1'b0, 1'b1);
		wr(ADDR_DATA[0] | 8'h06, 8'h00, 1'b1);
		wr(ADDR_DATA[0], 8'h01, 1'b1);
		settle(1);
		check(p0_out, 8'h1b);
		rchk(ADDR_DATA[0] | 8'h01, 8'h00, 1'b1);
		rchk(ADDR_DATA[0] | 8'h03, 8'h01, 1'b1);
		rchk(8'h00, 8'h00);
		p0_low = 8'h00;
	endtask : t_latch

	// Output mode, SMBus override, skip and drive registers.
	task automatic t_config();
		wr(ADDR_MDOUT[0], 8'hff);
		settle(1);
		check(p0_oe, 8'hff);
		p0_sm = 8'h03;
		settle(2);
		check(p0_oe, 8'hfc);
		for (int p = 0; p < 2; p++) begin
			wr(ADDR_SKIP[p], 8'h3c + pmio_byte_t'(p));
			wr(ADDR_DRV[p], 8'hc3 - pmio_byte_t'(p));
			rchk(ADDR_SKIP[p], 8'h3c + pmio_byte_t'(p));
			rchk(ADDR_DRV[p], 8'hc3 - pmio_byte_t'(p));
		end
		check(p1_skip, 8'h3d);
		check(p0_drv, 8'hc3);
		wr(ADDR_SKIP[2], 8'hff);
		wr(ADDR_DRV[2], 8'hff);
		settle(1);
		check({p2_skip, p2_drv, 6'h0}, 8'hc0);
		rchk(ADDR_SKIP[2], 8'h80);
		wr(ADDR_MDOUT[0], 8'h00);
		wr(ADDR_DATA[0], 8'hff);
		p0_sm = 8'h00;
	endtask : t_config

	// Analog input mode and the digital-only pin.
	task automatic t_analog();
		wr(ADDR_MDIN[0], 8'hf0);
		settle(6);
		check(p0_mdin, 8'hf0);
		rchk(ADDR_DATA[0], 8'hf0);
		wr(ADDR_MDIN[2], 8'h00);
		settle(6);
		rchk(ADDR_MDIN[2], 8'h80);
		rchk(ADDR_DATA[2], 8'h80);
		p2_low = 1'b1;
		settle(6);
		rchk(ADDR_DATA[2], 8'h00);
		p2_low = 1'b0;
		wr(ADDR_MDIN[0], 8'hff);
	endtask : t_analog

	// Masked comparison on each port in turn.
	task automatic t_match(input int p);
		wr(ADDR_MASK[p], 8'h0f);
		wr(ADDR_MAT[p], 8'h0f);
		wait_mis(1'b0);
		if (p == 0) p0_low = 8'h10; else p1_low = 8'h10;
		settle(8);
		wait_mis(1'b0);
		if (p == 0) p0_low = 8'h14; else p1_low = 8'h14;
		wait_mis(1'b1);
		wr(ADDR_MAT[p], 8'hfb);
		wait_mis(1'b0);
		wr(ADDR_MASK[p], 8'h00);
		p0_low = 8'h00;
		p1_low = 8'h00;
	endtask : t_match

	// Watchdog against a hang.
	initial begin
		#(3000 * 100);
		err_count++;
		stop_test();
	end

	// Reset, then the scenarios in order.
	initial begin
		{reset, sfr_bit, sfr_wr, sfr_rd, sfr_rmw, p2_low} = 6'b100000;
		{sfr_addr, sfr_wdata, p0_sm, p1_sm, p0_low, p1_low} = '0;
		err_count = 0;
		checked = 0;
		settle(6);
		reset = 1'b0;
		t_reset();
		t_latch();
		t_config();
		t_analog();
		t_match(0);
		t_match(1);
		stop_test();
	end
endmodule : pmio_port_io_tb
